// ===== inc/ram_tile_pkg.sv
package ram_tile_pkg;

    // storage geometry of one tile
    localparam int TILE_BITS = 4096;
    localparam int TILE_WORDS = 256;
    localparam int ROW_BITS = 16;
    localparam int ROW_IDX_BITS = 8;
    localparam int BIT_POS_BITS = 12;
    localparam int LANE_POS_BITS = 4;

    // widest port shapes carried on the carrier
    localparam int LOC_MAX = 11;
    localparam int WORD_MAX = 16;

    // documented arrangement: 256x16 with bit mask
    localparam int WORD_BITS_DEF = 16;

    // values after reset
    localparam logic [WORD_MAX-1:0] RD_WORD_RST = 16'h0000;
    localparam logic [LOC_MAX-1:0] LOC_RST = 11'h000;

    // pin input synchroniser depth
    localparam int SYNC_STAGES = 3;

    // port clock made by the fabric end from the reference clock
    localparam int REF_PERIOD_NS = 10;
    localparam int PORT_HALF_NS = 80;
    localparam int PORT_HALF_CYC = (PORT_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    localparam int PORT_HALF_MIN = 8;

    // log2 of a legal word width, 4 (as for 16) for anything unknown
    function automatic int width_log2(input int w);
        case (w)
            2: width_log2 = 1;
            4: width_log2 = 2;
            8: width_log2 = 3;
            default: width_log2 = 4;
        endcase
    endfunction

    // location width of each arrangement: 8, 9, 10 or 11
    function automatic int loc_bits(input int w);
        loc_bits = 12 - width_log2(w);
    endfunction

endpackage

// ===== inc/ram_tile_if.sv
`timescale 1ns/100ps
interface ram_tile_if;
    import ram_tile_pkg::*;

    // write port
    logic wr_clk;
    logic wr_strobe;
    logic wr_clock_gate;
    logic [LOC_MAX-1:0] wr_location;
    logic [WORD_MAX-1:0] wr_data;
    logic [WORD_MAX-1:0] wr_mask;

    // read port
    logic rd_clk;
    logic rd_strobe;
    logic rd_clock_gate;
    logic [LOC_MAX-1:0] rd_location;
    logic [WORD_MAX-1:0] rd_word;

    modport tile (
        input wr_clk, wr_strobe, wr_clock_gate, wr_location, wr_data, wr_mask,
        input rd_clk, rd_strobe, rd_clock_gate, rd_location,
        output rd_word
    );

    modport fabric (
        output wr_clk, wr_strobe, wr_clock_gate, wr_location, wr_data, wr_mask,
        output rd_clk, rd_strobe, rd_clock_gate, rd_location,
        input rd_word
    );

endinterface

// ===== rtl/ram_tile.sv
`timescale 1ns/100ps
module ram_tile
    import ram_tile_pkg::*;
#(
    parameter int WORD_BITS = WORD_BITS_DEF,
    parameter bit WR_FALLING = 1'b0,
    parameter bit RD_FALLING = 1'b0,
    parameter logic [TILE_BITS-1:0] INIT_IMAGE = '0
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    ram_tile_if.tile port_if
);

    // arrangement constants derived from the chosen width
    localparam int WIDTH_LOG = width_log2(WORD_BITS);
    localparam int ADDR_BITS = loc_bits(WORD_BITS);
    localparam logic [LOC_MAX-1:0] LOC_KEEP = LOC_MAX'((32'h1 << ADDR_BITS) - 32'h1);
    localparam logic [ROW_BITS-1:0] WIDTH_MASK = ROW_BITS'((32'h1 << WORD_BITS) - 32'h1);
    localparam bit HAS_MASK = (WORD_BITS == ROW_BITS);
    localparam logic WR_ACTIVE_LVL = ~WR_FALLING;
    localparam logic RD_ACTIVE_LVL = ~RD_FALLING;

    // flat storage, one row of 16 bits per index
    logic [ROW_BITS-1:0] store_reg [TILE_WORDS];

    // port clock synchronisers and filtered levels
    logic [SYNC_STAGES-1:0] wr_sync_reg;
    logic [SYNC_STAGES-1:0] rd_sync_reg;
    logic wr_lvl_reg;
    logic rd_lvl_reg;

    // captured write side
    logic [LOC_MAX-1:0] wr_loc_reg;
    logic [ROW_BITS-1:0] wr_data_reg;
    logic [ROW_BITS-1:0] wr_mask_reg;
    logic wr_go_reg;

    // captured read side
    logic [LOC_MAX-1:0] rd_loc_reg;
    logic rd_go_reg;
    logic [ROW_BITS-1:0] rd_word_reg;

    // port clocks are sampled like pins; the first stage
    // is read only by the second stage
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wr_sync_reg <= '0;
            rd_sync_reg <= '0;
        end else begin
            wr_sync_reg <= {wr_sync_reg[SYNC_STAGES-2:0], port_if.wr_clk};
            rd_sync_reg <= {rd_sync_reg[SYNC_STAGES-2:0], port_if.rd_clk};
        end
    end

    // a level change counts once stages two and three agree
    logic wr_stable;
    logic rd_stable;
    logic wr_edge;
    logic rd_edge;
    assign wr_stable = (wr_sync_reg[1] == wr_sync_reg[2]);
    assign rd_stable = (rd_sync_reg[1] == rd_sync_reg[2]);
    assign wr_edge = wr_stable && (wr_sync_reg[2] != wr_lvl_reg) && (wr_sync_reg[2] == WR_ACTIVE_LVL);
    assign rd_edge = rd_stable && (rd_sync_reg[2] != rd_lvl_reg) && (rd_sync_reg[2] == RD_ACTIVE_LVL);

    // filtered level starts where the synchroniser starts, so a port clock
    // that idles low after reset gives no false edge in falling mode either
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wr_lvl_reg <= 1'b0;
            rd_lvl_reg <= 1'b0;
        end else begin
            if (wr_stable) begin
                wr_lvl_reg <= wr_sync_reg[2];
            end
            if (rd_stable) begin
                rd_lvl_reg <= rd_sync_reg[2];
            end
        end
    end

    // the gate acts as a clock enable; the strobe decides the action
    logic wr_take;
    logic rd_take;
    assign wr_take = wr_edge && port_if.wr_clock_gate;
    assign rd_take = rd_edge && port_if.rd_clock_gate;

    // a strobed capture becomes a write or read one cycle later
    logic wr_hit;
    logic rd_hit;
    assign wr_hit = wr_take && port_if.wr_strobe;
    assign rd_hit = rd_take && port_if.rd_strobe;

    // input registers at the array boundary, write side
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wr_loc_reg <= LOC_RST;
            wr_data_reg <= '0;
            wr_mask_reg <= '1;
            wr_go_reg <= 1'b0;
        end else if (wr_take) begin
            wr_loc_reg <= port_if.wr_location;
            wr_data_reg <= port_if.wr_data;
            wr_mask_reg <= port_if.wr_mask;
            wr_go_reg <= wr_hit;
        end else begin
            wr_go_reg <= 1'b0;
        end
    end

    // input registers at the array boundary, read side
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rd_loc_reg <= LOC_RST;
            rd_go_reg <= 1'b0;
        end else if (rd_take) begin
            rd_loc_reg <= port_if.rd_location;
            rd_go_reg <= rd_hit;
        end else begin
            rd_go_reg <= 1'b0;
        end
    end

    // location bits above the shape are dropped on purpose, so a wide
    // location wraps inside the tile instead of reaching a missing row
    function automatic logic [BIT_POS_BITS-1:0] loc_to_pos(input logic [LOC_MAX-1:0] loc);
        logic [LOC_MAX-1:0] kept;
        kept = loc & LOC_KEEP;
        loc_to_pos = BIT_POS_BITS'(kept) << WIDTH_LOG;
    endfunction

    // location to bit position, shared by both ports
    logic [BIT_POS_BITS-1:0] wr_bit_pos;
    logic [BIT_POS_BITS-1:0] rd_bit_pos;
    assign wr_bit_pos = loc_to_pos(wr_loc_reg);
    assign rd_bit_pos = loc_to_pos(rd_loc_reg);

    // row index and lane offset inside the row
    logic [ROW_IDX_BITS-1:0] wr_row;
    logic [ROW_IDX_BITS-1:0] rd_row;
    logic [LANE_POS_BITS-1:0] wr_off;
    logic [LANE_POS_BITS-1:0] rd_off;
    assign wr_row = wr_bit_pos[BIT_POS_BITS-1:LANE_POS_BITS];
    assign rd_row = rd_bit_pos[BIT_POS_BITS-1:LANE_POS_BITS];
    assign wr_off = wr_bit_pos[LANE_POS_BITS-1:0];
    assign rd_off = rd_bit_pos[LANE_POS_BITS-1:0];

    // narrow shapes have no mask port: every lane bit is written
    logic [ROW_BITS-1:0] mask_eff;
    assign mask_eff = HAS_MASK ? wr_mask_reg : '0;

    // bits to change and their new values, placed in the lane
    logic [ROW_BITS-1:0] wr_bit_en;
    logic [ROW_BITS-1:0] wr_bits;
    assign wr_bit_en = (WIDTH_MASK << wr_off) & ~mask_eff;
    assign wr_bits = (wr_data_reg & WIDTH_MASK) << wr_off;

    // merged row written back; untouched bits keep their value
    logic [ROW_BITS-1:0] wr_row_next;
    assign wr_row_next = (store_reg[wr_row] & ~wr_bit_en) | (wr_bits & wr_bit_en);

    // lane read out of the addressed row
    logic [ROW_BITS-1:0] rd_word_next;
    assign rd_word_next = (store_reg[rd_row] >> rd_off) & WIDTH_MASK;

    // one register per row; reset stands for the configuration load
    logic [TILE_WORDS-1:0] row_wr;
    for (genvar g = 0; g < TILE_WORDS; g++) begin : g_row
        assign row_wr[g] = wr_go_reg && (wr_row == ROW_IDX_BITS'(g));
        always_ff @(posedge ref_clk_i) begin
            if (srst_i) begin
                store_reg[g] <= INIT_IMAGE[g*ROW_BITS +: ROW_BITS];
            end else if (row_wr[g]) begin
                store_reg[g] <= wr_row_next;
            end
        end
    end

    // read word holds unless the read was both strobed and gated;
    // a held word lets a slow reader take it any time later
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rd_word_reg <= RD_WORD_RST;
        end else if (rd_go_reg) begin
            rd_word_reg <= rd_word_next;
        end
    end

    // read data goes out straight from its register
    assign port_if.rd_word = rd_word_reg;

endmodule

// ===== rtl/ram_fabric.sv
`timescale 1ns/100ps
module ram_fabric
    import ram_tile_pkg::*;
#(
    parameter int WORD_BITS = WORD_BITS_DEF,
    parameter bit WR_FALLING = 1'b0,
    parameter bit RD_FALLING = 1'b0,
    parameter bit ROM_ONLY = 1'b0,
    parameter int HALF_CYC = PORT_HALF_CYC
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic wr_req_i,
    input wire logic [LOC_MAX-1:0] wr_loc_i,
    input wire logic [WORD_MAX-1:0] wr_data_i,
    input wire logic [WORD_MAX-1:0] wr_mask_i,
    output logic wr_ready_o,
    output logic wr_done_o,
    input wire logic rd_req_i,
    input wire logic [LOC_MAX-1:0] rd_loc_i,
    output logic rd_ready_o,
    output logic rd_valid_o,
    output logic [WORD_MAX-1:0] rd_data_o,
    ram_tile_if.fabric port_if
);

    // slower half periods leave the tile time to sample and answer
    localparam int HALF_USE = (HALF_CYC < PORT_HALF_MIN) ? PORT_HALF_MIN : HALF_CYC;
    localparam int CNT_BITS = $clog2(HALF_USE + 1);
    localparam logic [CNT_BITS-1:0] CNT_LAST = CNT_BITS'(HALF_USE - 1);

    logic [CNT_BITS-1:0] cnt_reg;
    logic clk_lvl_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic [LOC_MAX-1:0] wr_loc_reg;
    logic [WORD_MAX-1:0] wr_data_reg;
    logic [WORD_MAX-1:0] wr_mask_reg;
    logic [LOC_MAX-1:0] rd_loc_reg;
    logic wr_drive_reg;
    logic rd_drive_reg;
    logic wr_done_reg;
    logic rd_valid_reg;
    logic [WORD_MAX-1:0] rd_data_reg;

    // port clock divider, both port clocks share one phase
    logic tick;
    assign tick = (cnt_reg == CNT_LAST);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cnt_reg <= '0;
            clk_lvl_reg <= 1'b0;
        end else begin
            cnt_reg <= tick ? '0 : cnt_reg + 1'b1;
            clk_lvl_reg <= tick ? ~clk_lvl_reg : clk_lvl_reg;
        end
    end

    // launch on the inactive edge so signals are steady at the active one
    logic wr_launch;
    logic rd_launch;
    assign wr_launch = tick && (~clk_lvl_reg == WR_FALLING);
    assign rd_launch = tick && (~clk_lvl_reg == RD_FALLING);

    // a request is taken only while the matching ready is high
    logic wr_accept;
    logic rd_accept;
    assign wr_accept = wr_req_i && !wr_pend_reg && !ROM_ONLY;
    assign rd_accept = rd_req_i && !rd_pend_reg;

    // write side: hold a request, drive strobe and gate for one period
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wr_pend_reg <= 1'b0;
            wr_drive_reg <= 1'b0;
            wr_done_reg <= 1'b0;
            wr_loc_reg <= LOC_RST;
            wr_data_reg <= '0;
            wr_mask_reg <= '1;
        end else begin
            wr_done_reg <= wr_launch && wr_drive_reg;
            if (wr_accept) begin
                wr_pend_reg <= 1'b1;
                wr_loc_reg <= wr_loc_i;
                wr_data_reg <= wr_data_i;
                wr_mask_reg <= wr_mask_i;
            end else if (wr_launch && wr_drive_reg) begin
                wr_pend_reg <= 1'b0;
            end
            if (wr_launch) begin
                wr_drive_reg <= wr_pend_reg && !wr_drive_reg;
            end
        end
    end

    // read side: same shape, word sampled one period after launch
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rd_pend_reg <= 1'b0;
            rd_drive_reg <= 1'b0;
            rd_valid_reg <= 1'b0;
            rd_loc_reg <= LOC_RST;
            rd_data_reg <= RD_WORD_RST;
        end else begin
            rd_valid_reg <= rd_launch && rd_drive_reg;
            if (rd_launch && rd_drive_reg) begin
                rd_data_reg <= port_if.rd_word;
            end
            if (rd_accept) begin
                rd_pend_reg <= 1'b1;
                rd_loc_reg <= rd_loc_i;
            end else if (rd_launch && rd_drive_reg) begin
                rd_pend_reg <= 1'b0;
            end
            if (rd_launch) begin
                rd_drive_reg <= rd_pend_reg && !rd_drive_reg;
            end
        end
    end

    // carrier outputs, write controls stay idle for read-only use
    assign port_if.wr_clk = clk_lvl_reg;
    assign port_if.rd_clk = clk_lvl_reg;
    assign port_if.wr_strobe = wr_drive_reg;
    assign port_if.wr_clock_gate = wr_drive_reg;
    assign port_if.wr_location = wr_loc_reg;
    assign port_if.wr_data = wr_data_reg;
    assign port_if.wr_mask = wr_mask_reg;
    assign port_if.rd_strobe = rd_drive_reg;
    assign port_if.rd_clock_gate = rd_drive_reg;
    assign port_if.rd_location = rd_loc_reg;

    // user outputs
    assign wr_ready_o = !wr_pend_reg && !ROM_ONLY;
    assign wr_done_o = wr_done_reg;
    assign rd_ready_o = !rd_pend_reg;
    assign rd_valid_o = rd_valid_reg;
    assign rd_data_o = rd_data_reg;

endmodule

// ===== tb/ram_tile_checker.sv
`timescale 1ns/100ps
module ram_tile_checker
    import ram_tile_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic wr_clk,
    input wire logic wr_strobe,
    input wire logic wr_clock_gate,
    input wire logic [LOC_MAX-1:0] wr_location,
    input wire logic [WORD_MAX-1:0] wr_data,
    input wire logic [WORD_MAX-1:0] wr_mask,
    input wire logic rd_clk,
    input wire logic rd_strobe,
    input wire logic rd_clock_gate,
    input wire logic [LOC_MAX-1:0] rd_location,
    input wire logic [WORD_MAX-1:0] rd_word
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    // read word only moves while a gated, strobed read is open
    AST_RD_GATED: assert property ($changed(rd_word) |-> rd_strobe && rd_clock_gate)
        else $error("read word changed without strobe and gate");
    // rising is the default read edge, so a new word lands in the high phase
    AST_RD_IN_HIGH: assert property ($changed(rd_word) |-> rd_clk)
        else $error("read word changed outside the high phase");
    // strobe and gate open together while the port clock is low
    AST_WR_PAIR: assert property ($rose(wr_strobe) |-> !wr_clk && wr_clock_gate)
        else $error("write strobe opened without gate or in the high phase");
    AST_RD_PAIR: assert property ($rose(rd_strobe) |-> !rd_clk && rd_clock_gate)
        else $error("read strobe opened without gate or in the high phase");
    // inputs must be settled before the edge that registers them and held for four cycles after it
    AST_WR_SETUP: assert property ($rose(wr_clk) && wr_strobe |-> $stable(wr_location) && $stable(wr_data))
        else $error("write inputs moved at the write edge");
    AST_WR_HOLD: assert property ($rose(wr_clk) && wr_strobe |=> (wr_strobe && $stable(wr_data)) [*4])
        else $error("write inputs dropped too soon after the edge");
    AST_WR_LEAD: assert property ($rose(wr_strobe) |-> ##[1:10] $rose(wr_clk))
        else $error("no rising write edge after strobe");
    // registered array input: no word can appear within three cycles of the edge
    AST_RD_LATENCY: assert property ($rose(rd_clk) |-> $stable(rd_word) [*3])
        else $error("read word moved too early after the read edge");
    AST_RST_CLEAR: assert property (disable iff (1'b0) srst_i |=> rd_word == RD_WORD_RST && !wr_strobe)
        else $error("reset did not clear read word or write strobe");

    COV_WRITE: cover property ($rose(wr_clk) && wr_strobe);
    COV_READ: cover property ($rose(rd_clk) && rd_strobe);
    COV_MASKED: cover property ($rose(wr_clk) && wr_strobe && wr_mask != 16'hFFFF && wr_mask != 16'h0000);
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import ram_tile_pkg::*;
    // row 5 preloaded, as a configuration image would
    localparam logic [TILE_BITS-1:0] PRELOAD = TILE_BITS'(16'hA5C3) << 80;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic wr_req_i = 1'b0;
    logic rd_req_i = 1'b0;
    logic [LOC_MAX-1:0] wr_loc_i = 11'h000;
    logic [LOC_MAX-1:0] rd_loc_i = 11'h000;
    logic [WORD_MAX-1:0] wr_data_i = 16'h0000;
    logic [WORD_MAX-1:0] wr_mask_i = 16'h0000;
    logic wr_ready_o, wr_done_o, rd_ready_o, rd_valid_o;
    logic [WORD_MAX-1:0] rd_data_o;
    logic wr_req_c = 1'b0;
    logic rd_req_c = 1'b0;
    logic wr_ready_c, wr_done_c, rd_ready_c, rd_valid_c, wr_ready_d;
    logic [WORD_MAX-1:0] rd_data_c, rd_data_d;
    logic rom_wr_seen = 1'b0;
    int n_errors = 0;
    int tests_run = 0;

    ram_tile_if bus_a ();
    ram_tile_if bus_b ();

    always #5 ref_clk_i = ~ref_clk_i;

    ram_tile #(.INIT_IMAGE(PRELOAD)) ram_tile_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .port_if(bus_a));
    ram_fabric ram_fabric_inst (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_req_i(wr_req_i), .wr_loc_i(wr_loc_i),
        .wr_data_i(wr_data_i), .wr_mask_i(wr_mask_i), .wr_ready_o(wr_ready_o), .wr_done_o(wr_done_o),
        .rd_req_i(rd_req_i), .rd_loc_i(rd_loc_i), .rd_ready_o(rd_ready_o), .rd_valid_o(rd_valid_o),
        .rd_data_o(rd_data_o), .port_if(bus_a)
    );
    // second tile, driven directly so strobe and gate can be split
    ram_tile ram_tile_b_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .port_if(bus_b));
    ram_tile_checker ram_tile_checker_inst (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_clk(bus_a.wr_clk), .wr_strobe(bus_a.wr_strobe),
        .wr_clock_gate(bus_a.wr_clock_gate), .wr_location(bus_a.wr_location), .wr_data(bus_a.wr_data),
        .wr_mask(bus_a.wr_mask), .rd_clk(bus_a.rd_clk), .rd_strobe(bus_a.rd_strobe),
        .rd_clock_gate(bus_a.rd_clock_gate), .rd_location(bus_a.rd_location), .rd_word(bus_a.rd_word)
    );

    ram_tile_if bus_c ();
    ram_tile_if bus_d ();
    // byte-wide pair working on falling edges
    ram_tile #(.WORD_BITS(8), .WR_FALLING(1'b1), .RD_FALLING(1'b1)) ram_tile_c_inst (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .port_if(bus_c)
    );
    ram_fabric #(.WORD_BITS(8), .WR_FALLING(1'b1), .RD_FALLING(1'b1)) ram_fabric_c_inst (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_req_i(wr_req_c), .wr_loc_i(wr_loc_i),
        .wr_data_i(wr_data_i), .wr_mask_i(wr_mask_i), .wr_ready_o(wr_ready_c), .wr_done_o(wr_done_c),
        .rd_req_i(rd_req_c), .rd_loc_i(rd_loc_i), .rd_ready_o(rd_ready_c), .rd_valid_o(rd_valid_c),
        .rd_data_o(rd_data_c), .port_if(bus_c)
    );
    // read-only pair, in lockstep with the first pair's requests
    ram_tile #(.INIT_IMAGE(PRELOAD)) ram_tile_d_inst (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .port_if(bus_d));
    ram_fabric #(.ROM_ONLY(1'b1)) ram_fabric_d_inst (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wr_req_i(wr_req_i), .wr_loc_i(wr_loc_i),
        .wr_data_i(wr_data_i), .wr_mask_i(wr_mask_i), .wr_ready_o(wr_ready_d), .wr_done_o(),
        .rd_req_i(rd_req_i), .rd_loc_i(rd_loc_i), .rd_ready_o(), .rd_valid_o(),
        .rd_data_o(rd_data_d), .port_if(bus_d)
    );

    // any write control on the read-only carrier is remembered
    always @(posedge ref_clk_i) begin
        if (!srst_i && (bus_d.wr_strobe !== 1'b0 || bus_d.wr_clock_gate !== 1'b0)) begin
            rom_wr_seen <= 1'b1;
        end
    end

    task automatic wrap_up();
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [WORD_MAX-1:0] got, input logic [WORD_MAX-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one bounded wait step; running out ends the run
    task automatic step(inout int n);
        n++;
        if (n > 300) begin
            n_errors++;
            $display("unexpected at %0t: handshake timeout", $time);
            wrap_up();
        end else begin
            @(posedge ref_clk_i);
            #1;
        end
    endtask

    // c selects the byte-wide pair instead of the first pair
    task automatic wr(input bit c, input logic [LOC_MAX-1:0] loc, input logic [WORD_MAX-1:0] d,
                      input logic [WORD_MAX-1:0] m);
        int n;
        n = 0;
        while ((c ? wr_ready_c : wr_ready_o) !== 1'b1) step(n);
        wr_req_i = !c;
        wr_req_c = c;
        wr_loc_i = loc;
        wr_data_i = d;
        wr_mask_i = m;
        @(posedge ref_clk_i);
        #1;
        wr_req_i = 1'b0;
        wr_req_c = 1'b0;
        while ((c ? wr_done_c : wr_done_o) !== 1'b1) step(n);
    endtask

    task automatic rd(input bit c, input logic [LOC_MAX-1:0] loc, input logic [WORD_MAX-1:0] e);
        int n;
        n = 0;
        while ((c ? rd_ready_c : rd_ready_o) !== 1'b1) step(n);
        rd_req_i = !c;
        rd_req_c = c;
        rd_loc_i = loc;
        @(posedge ref_clk_i);
        #1;
        rd_req_i = 1'b0;
        rd_req_c = 1'b0;
        while ((c ? rd_valid_c : rd_valid_o) !== 1'b1) step(n);
        chk(c ? rd_data_c : rd_data_o, e);
    endtask

    task automatic b_set(input logic ws, wg, rs, rg, input logic [LOC_MAX-1:0] loc, input logic [WORD_MAX-1:0] d);
        bus_b.wr_strobe = ws;
        bus_b.wr_clock_gate = wg;
        bus_b.rd_strobe = rs;
        bus_b.rd_clock_gate = rg;
        bus_b.wr_location = loc;
        bus_b.rd_location = loc;
        bus_b.wr_data = d;
        bus_b.wr_mask = 16'h0000;
    endtask

    // one port-clock period; inputs held 8 cycles before the rising edge and 16 after it
    task automatic b_op(input logic ws, wg, rs, rg, input logic [LOC_MAX-1:0] loc, input logic [WORD_MAX-1:0] d);
        b_set(ws, wg, rs, rg, loc, d);
        repeat (8) @(posedge ref_clk_i);
        #1 bus_b.wr_clk = 1'b1;
        bus_b.rd_clk = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1 bus_b.wr_clk = 1'b0;
        bus_b.rd_clk = 1'b0;
        repeat (8) @(posedge ref_clk_i);
        #1 b_set(1'b0, 1'b0, 1'b0, 1'b0, ~loc, ~d);
        @(posedge ref_clk_i);
        #1;
    endtask

    initial begin
        bus_b.wr_clk = 1'b0;
        bus_b.rd_clk = 1'b0;
        b_set(1'b0, 1'b0, 1'b0, 1'b0, 11'h000, 16'h0000);
        repeat (12) @(posedge ref_clk_i);
        #1 srst_i = 1'b0;
        rd(1'b0, 11'h005, 16'hA5C3);
        chk(rd_data_d, 16'hA5C3);
        wr(1'b0, 11'h000, 16'h1234, 16'h0000);
        wr(1'b0, 11'h001, 16'hBEEF, 16'h0000);
        rd(1'b0, 11'h000, 16'h1234);
        chk({rd_data_d[15:8], rd_data_o[7:0]}, 16'h0034);
        rd(1'b0, 11'h001, 16'hBEEF);
        wr(1'b0, 11'h0FF, 16'hFFFF, 16'h00FF);
        rd(1'b0, 11'h0FF, 16'hFF00);
        wr(1'b0, 11'h000, 16'h0000, 16'hFFFF);
        rd(1'b0, 11'h000, 16'h1234);
        wr(1'b0, 11'h702, 16'h4321, 16'h0000);
        rd(1'b0, 11'h002, 16'h4321);
        rd(1'b0, 11'h501, 16'hBEEF);
        wr(1'b1, 11'h000, 16'h00AB, 16'h0000);
        wr(1'b1, 11'h001, 16'h00CD, 16'h0000);
        rd(1'b1, 11'h000, 16'h00AB);
        rd(1'b1, 11'h001, 16'h00CD);
        wr(1'b1, 11'h005, 16'hFF77, 16'hFFFF);
        rd(1'b1, 11'h005, 16'h0077);
        wr(1'b1, 11'h3FF, 16'h005A, 16'h0000);
        rd(1'b1, 11'h1FF, 16'h005A);
        // second reset in mid-run reloads the configuration image
        srst_i = 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1 srst_i = 1'b0;
        rd(1'b0, 11'h005, 16'hA5C3);
        rd(1'b0, 11'h000, 16'h0000);
        b_op(1'b1, 1'b1, 1'b0, 1'b0, 11'h003, 16'h5A5A);
        b_op(1'b0, 1'b0, 1'b1, 1'b1, 11'h003, 16'h0000);
        chk(bus_b.rd_word, 16'h5A5A);
        b_op(1'b1, 1'b0, 1'b0, 1'b0, 11'h003, 16'h0F0F);
        b_op(1'b0, 1'b1, 1'b0, 1'b0, 11'h003, 16'h0F0F);
        b_op(1'b0, 1'b0, 1'b1, 1'b1, 11'h003, 16'h0000);
        chk(bus_b.rd_word, 16'h5A5A);
        b_op(1'b0, 1'b0, 1'b1, 1'b0, 11'h004, 16'h0000);
        chk(bus_b.rd_word, 16'h5A5A);
        b_op(1'b0, 1'b0, 1'b0, 1'b1, 11'h004, 16'h0000);
        chk(bus_b.rd_word, 16'h5A5A);
        b_op(1'b0, 1'b0, 1'b1, 1'b1, 11'h004, 16'h0000);
        chk(bus_b.rd_word, 16'h0000);
        chk({15'h0000, wr_ready_d}, 16'h0000);
        chk({15'h0000, rom_wr_seen}, 16'h0000);
        wrap_up();
    end
endmodule
